// ==== design/rce_sixteen_bit_counting_mode_control.sv ====
// Design decision made here: the AXI4-Lite register port.
module rce_sixteen_bit_counting_mode_control
  import rce_pkg::*;
#(
  parameter int unsigned TAMPER_INPUTS = 5
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [9:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [9:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [15:0] count_i,
  input wire logic overflow_i,
  input wire logic [3:0] match_i,
  input wire logic [7:0] interval_i,
  input wire logic tamper_detect_i,
  input wire logic tamper_capture_evt_i,
  input wire logic [TAMPER_INPUTS-1:0] tamper_pin_i,
  output rce_irq_t evt_o,
  output logic irq_o,
  output logic dma_req_o,
  output logic active_layer_clk_o,
  output logic [TAMPER_INPUTS-1:0] tamper_level_o,
  output logic [3:0] match_channel_on_o,
  output logic [3:0] spare_regs_on_o,
  output logic enabled_o,
  output logic debug_run_o
);

  logic aw_held;
  logic w_held;
  logic [9:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic enable_bit;
  logic enabled;
  logic [1:0] soft_reset_trigger_cnt;
  logic [1:0] en_cnt;
  rce_ctrl2_t ctrl2;
  logic [31:0] event_control;
  rce_irq_t inten;
  rce_irq_t flags;
  logic [15:0] timestamp;
  logic debug_run;
  logic [7:0] div_cnt;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;

  // Bus handshake
  wire aw_take = s_axi_awvalid_i && !aw_held;
  wire w_take = s_axi_wvalid_i && !w_held;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid_o;
  wire rd_fire = s_axi_arvalid_i && !s_axi_rvalid_o;
  assign s_axi_awready_o = !aw_held;
  assign s_axi_wready_o = !w_held;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  // Write decode
  wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0] wbits = wr_data & wmask;
  wire hit_c1 = wr_fire && (wr_addr == A_CONTROL_ONE);
  wire hit_c2 = wr_fire && (wr_addr == A_CONTROL_TWO);
  wire hit_ev = wr_fire && (wr_addr == A_EVENT_CONTROL);
  wire hit_clr = wr_fire && (wr_addr == A_IRQ_ENABLE_CLEAR);
  wire hit_set = wr_fire && (wr_addr == A_IRQ_ENABLE_SET);
  wire hit_flags = wr_fire && (wr_addr == A_IRQ_FLAGS);
  wire hit_dbg = wr_fire && (wr_addr == A_DEBUG_HALT_CONTROL);
  wire wr_mapped = hit_c1 || hit_c2 || hit_ev || hit_clr || hit_set || hit_flags || hit_dbg
                   || (wr_addr == A_SYNC_PENDING_STATUS) || (wr_addr == A_TIMESTAMP);

  wire soft_reset_trigger_busy = soft_reset_trigger_cnt != 2'h0;
  wire soft_reset_trigger_done = soft_reset_trigger_cnt == 2'h1;
  wire en_busy = en_cnt != 2'h0;
  wire soft_reset_trigger_req = hit_c1 && wbits[C1_SOFT_RESET_BIT];
  wire en_write = hit_c1 && wmask[C1_ENABLE_BIT] && !soft_reset_trigger_req && !soft_reset_trigger_busy;
  wire protected_ok = !enable_bit && !enabled && !soft_reset_trigger_busy;
  wire c2_write = hit_c2 && protected_ok;
  wire ev_write = hit_ev && protected_ok;
  wire ts_read = rd_fire && (s_axi_araddr_i == A_TIMESTAMP);
  wire ts_capture = enabled && event_control[EV_TAMPER_IN_BIT] && tamper_capture_evt_i;

  wire [15:0] next_ctrl2 = (ctrl2 & ~wmask[15:0]) | (wbits[15:0] & CONTROL_TWO_MASK);
  wire [31:0] next_event_control = (event_control & ~wmask) | (wbits & EVENT_CONTROL_MASK);
  wire [15:0] set_bits = wbits[15:0] & IRQ_MASK;
  wire [15:0] next_inten = hit_set ? (inten | set_bits) : (inten & ~set_bits);

  // Match channels 0 and 1 give way to spare registers; channels 2 and 3 stay on
  assign match_channel_on_o = {2'h3, ~ctrl2.upper_spare_regs_select, ~ctrl2.lower_spare_regs_select};
  assign spare_regs_on_o = {{2{ctrl2.upper_spare_regs_select}}, {2{ctrl2.lower_spare_regs_select}}};

  // Hardware sources, gated by the block enable and channel use
  rce_irq_t src;
  assign src.overflow_source = enabled && overflow_i;
  assign src.tamper = enabled && tamper_detect_i;
  assign src.spare = 2'h0;
  assign src.match_source = enabled ? (match_i & match_channel_on_o) : 4'h0;
  assign src.interval_source = enabled ? interval_i : 8'h00;

  // Flag clears; a source in the same cycle wins
  wire [15:0] flag_clr = (hit_flags ? set_bits : 16'h0000)
                         | ((ts_read && ctrl2.timestamp_dma_request_on) ? 16'h4000 : 16'h0000);
  wire [15:0] next_flags = (flags & ~flag_clr) | src;

  // Event outputs gated by their enables
  rce_irq_t next_evt;
  assign next_evt.overflow_source = src.overflow_source && event_control[EV_OVERFLOW_OUT_BIT];
  assign next_evt.tamper = src.tamper && event_control[EV_TAMPER_OUT_BIT];
  assign next_evt.spare = 2'h0;
  assign next_evt.match_source = src.match_source & event_control[11:8];
  assign next_evt.interval_source = src.interval_source & event_control[7:0];

  // Divider tap for the debounce sample tick
  wire [8:0] deb_span = 9'h002 << ctrl2.debounce_divider;
  wire [8:0] deb_mask = deb_span - 9'h001;
  wire deb_tick = enabled && ((div_cnt & deb_mask[7:0]) == deb_mask[7:0]);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 10'h000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr_i;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (w_take)
      begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata_i;
        wr_strb <= s_axi_wstrb_i;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
  end

  always_comb
  begin
    rd_resp = RESP_OKAY;
    if (s_axi_araddr_i == A_CONTROL_ONE)
      rd_data = {30'h00000000, enable_bit, soft_reset_trigger_busy};
    else if (s_axi_araddr_i == A_CONTROL_TWO)
      rd_data = {16'h0000, ctrl2};
    else if (s_axi_araddr_i == A_EVENT_CONTROL)
      rd_data = event_control;
    else if (s_axi_araddr_i == A_IRQ_ENABLE_CLEAR || s_axi_araddr_i == A_IRQ_ENABLE_SET)
      rd_data = {16'h0000, inten};
    else if (s_axi_araddr_i == A_IRQ_FLAGS)
      rd_data = {16'h0000, flags};
    else if (s_axi_araddr_i == A_DEBUG_HALT_CONTROL)
      rd_data = {31'h00000000, debug_run};
    else if (s_axi_araddr_i == A_SYNC_PENDING_STATUS)
      rd_data = {30'h00000000, en_busy, soft_reset_trigger_busy};
    else if (s_axi_araddr_i == A_TIMESTAMP)
      rd_data = {16'h0000, timestamp};
    else
    begin
      rd_data = 32'h00000000;
      rd_resp = RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_data;
      s_axi_rresp_o <= rd_resp;
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  // Soft reset and enable synchronisation
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      soft_reset_trigger_cnt <= 2'h0;
    else if (soft_reset_trigger_req && !soft_reset_trigger_busy)
      soft_reset_trigger_cnt <= SYNC_CYCLES;
    else if (soft_reset_trigger_busy)
      soft_reset_trigger_cnt <= soft_reset_trigger_cnt - 2'h1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      enable_bit <= 1'b0;
      enabled <= 1'b0;
      en_cnt <= 2'h0;
    end
    else if (soft_reset_trigger_done)
    begin
      enable_bit <= 1'b0;
      enabled <= 1'b0;
      en_cnt <= 2'h0;
    end
    else if (en_write)
    begin
      enable_bit <= wr_data[C1_ENABLE_BIT];
      en_cnt <= SYNC_CYCLES;
    end
    else if (en_busy)
    begin
      en_cnt <= en_cnt - 2'h1;
      if (en_cnt == 2'h1)
        enabled <= enable_bit;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl2 <= rce_ctrl2_t'(CONTROL_TWO_RESET);
      event_control <= EVENT_CONTROL_RESET;
      inten <= rce_irq_t'(IRQ_RESET);
      flags <= rce_irq_t'(IRQ_RESET);
    end
    else if (soft_reset_trigger_done)
    begin
      ctrl2 <= rce_ctrl2_t'(CONTROL_TWO_RESET);
      event_control <= EVENT_CONTROL_RESET;
      inten <= rce_irq_t'(IRQ_RESET);
      flags <= rce_irq_t'(IRQ_RESET);
    end
    else
    begin
      if (c2_write)
        ctrl2 <= rce_ctrl2_t'(next_ctrl2);
      if (ev_write)
        event_control <= next_event_control;
      if (hit_set || hit_clr)
        inten <= rce_irq_t'(next_inten);
      flags <= rce_irq_t'(next_flags);
    end
  end

  // Timestamp capture and DMA request; a capture beats a read
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      timestamp <= 16'h0000;
      dma_req_o <= 1'b0;
    end
    else if (soft_reset_trigger_done)
    begin
      timestamp <= 16'h0000;
      dma_req_o <= 1'b0;
    end
    else if (ts_capture)
    begin
      timestamp <= count_i;
      dma_req_o <= ctrl2.timestamp_dma_request_on;
    end
    else if (ts_read)
      dma_req_o <= 1'b0;
  end

  // Debug run bit survives soft reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      debug_run <= DEBUG_RESET;
    else if (hit_dbg && wmask[0])
      debug_run <= wr_data[0];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_cnt <= 8'h00;
      active_layer_clk_o <= 1'b0;
      evt_o <= rce_irq_t'(IRQ_RESET);
    end
    else
    begin
      div_cnt <= enabled ? div_cnt + 8'h01 : 8'h00;
      active_layer_clk_o <= enabled && ctrl2.active_layer_output_on
                            && div_cnt[ctrl2.active_layer_divider];
      evt_o <= next_evt;
    end
  end

  assign irq_o = |(flags & inten);
  assign enabled_o = enabled;
  assign debug_run_o = debug_run;

  // Tamper input debouncers
  for (genvar g = 0; g < TAMPER_INPUTS; g++)
  begin : g_deb
    logic [2:0] pin_sync;
    logic stable;
    logic [2:0] hist;
    logic level;
    wire all_eq = (hist == 3'h7) || (hist == 3'h0);
    wire maj = (hist[0] & hist[1]) | (hist[0] & hist[2]) | (hist[1] & hist[2]);
    always_ff @(posedge clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        pin_sync <= 3'h0;
        stable <= 1'b0;
        hist <= 3'h0;
        level <= 1'b0;
      end
      else
      begin
        pin_sync <= {pin_sync[1:0], tamper_pin_i[g]};
        if (pin_sync[1] == pin_sync[2])
          stable <= pin_sync[2];
        if (deb_tick)
          hist <= {hist[1:0], stable};
        if (ctrl2.debouncer_async_select)
          level <= stable;
        else if (ctrl2.debouncer_majority_select)
          level <= maj;
        else if (all_eq)
          level <= hist[0];
      end
    end
    assign tamper_level_o[g] = level;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_soft_reset_trigger_clears;
    soft_reset_trigger_done |=> (ctrl2 == CONTROL_TWO_RESET) && (event_control == EVENT_CONTROL_RESET) && !enabled_o && !irq_o;
  endproperty
  a_soft_reset_trigger_clears: assert property (p_soft_reset_trigger_clears) else $error("soft reset left state");

  property p_soft_reset_trigger_wins;
    (soft_reset_trigger_req && !soft_reset_trigger_busy && !en_busy) |=> $stable(enable_bit) && !en_busy;
  endproperty
  a_soft_reset_trigger_wins: assert property (p_soft_reset_trigger_wins) else $error("soft reset did not discard write");

  property p_soft_reset_trigger_reads;
    (soft_reset_trigger_req && !soft_reset_trigger_busy) |=> soft_reset_trigger_busy [*3] ##1 !soft_reset_trigger_busy;
  endproperty
  a_soft_reset_trigger_reads: assert property (p_soft_reset_trigger_reads) else $error("soft reset busy length wrong");

  property p_enable_busy;
    en_write |=> en_busy ##1 en_busy ##1 en_busy ##1 (!en_busy && enabled_o == enable_bit);
  endproperty
  a_enable_busy: assert property (p_enable_busy) else $error("enable sync timing wrong");

  property p_disabled_quiet;
    !enabled |=> (evt_o == IRQ_RESET);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("event while disabled");

  property p_protect;
    (hit_c2 && (enable_bit || enabled) && !soft_reset_trigger_done) |=> $stable(ctrl2);
  endproperty
  a_protect: assert property (p_protect) else $error("protected write accepted");

  property p_w1s;
    (hit_set && !soft_reset_trigger_done) |=> ((inten & $past(set_bits)) == $past(set_bits));
  endproperty
  a_w1s: assert property (p_w1s) else $error("enable set failed");

  property p_w1c;
    (hit_clr && !soft_reset_trigger_done) |=> ((inten & $past(set_bits)) == 16'h0000)
      && ((inten | $past(set_bits)) == ($past(inten) | $past(set_bits)));
  endproperty
  a_w1c: assert property (p_w1c) else $error("enable clear failed");

  property p_ovf_evt;
    (enabled && overflow_i) |=> (evt_o.overflow_source == $past(event_control[EV_OVERFLOW_OUT_BIT]));
  endproperty
  a_ovf_evt: assert property (p_ovf_evt) else $error("overflow event gating wrong");

  property p_dma;
    (ts_capture && ctrl2.timestamp_dma_request_on && !soft_reset_trigger_done) |=> dma_req_o && (timestamp == $past(count_i));
  endproperty
  a_dma: assert property (p_dma) else $error("no dma request after capture");

  property p_flag_set_wins;
    (src.tamper && flag_clr[14] && !soft_reset_trigger_done) |=> flags.tamper;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("tamper flag lost");

  property p_alclk_off;
    !ctrl2.active_layer_output_on |=> !active_layer_clk_o;
  endproperty
  a_alclk_off: assert property (p_alclk_off) else $error("active layer clock not gated");

  c_soft_reset_trigger: cover property (soft_reset_trigger_req ##1 soft_reset_trigger_busy [*3] ##1 !soft_reset_trigger_busy);
  c_enable: cover property (en_write ##4 enabled_o);
  c_irq: cover property (!irq_o ##1 irq_o);
  c_dma: cover property (dma_req_o ##[1:20] !dma_req_o);

endmodule : rce_sixteen_bit_counting_mode_control

// ==== design/rce_pkg.sv ====
package rce_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL_ONE = 8'h00;
  localparam logic [7:0] IDX_CONTROL_TWO = 8'h02;
  localparam logic [7:0] IDX_EVENT_CONTROL = 8'h04;
  localparam logic [7:0] IDX_IRQ_ENABLE_CLEAR = 8'h08;
  localparam logic [7:0] IDX_IRQ_ENABLE_SET = 8'h0A;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_DEBUG_HALT_CONTROL = 8'h0E;
  localparam logic [7:0] IDX_SYNC_PENDING_STATUS = 8'h10;
  localparam logic [7:0] IDX_TIMESTAMP = 8'h64;

  localparam logic [9:0] A_CONTROL_ONE = {IDX_CONTROL_ONE, 2'h0};
  localparam logic [9:0] A_CONTROL_TWO = {IDX_CONTROL_TWO, 2'h0};
  localparam logic [9:0] A_EVENT_CONTROL = {IDX_EVENT_CONTROL, 2'h0};
  localparam logic [9:0] A_IRQ_ENABLE_CLEAR = {IDX_IRQ_ENABLE_CLEAR, 2'h0};
  localparam logic [9:0] A_IRQ_ENABLE_SET = {IDX_IRQ_ENABLE_SET, 2'h0};
  localparam logic [9:0] A_IRQ_FLAGS = {IDX_IRQ_FLAGS, 2'h0};
  localparam logic [9:0] A_DEBUG_HALT_CONTROL = {IDX_DEBUG_HALT_CONTROL, 2'h0};
  localparam logic [9:0] A_SYNC_PENDING_STATUS = {IDX_SYNC_PENDING_STATUS, 2'h0};
  localparam logic [9:0] A_TIMESTAMP = {IDX_TIMESTAMP, 2'h0};

  // Field positions
  localparam int unsigned C1_SOFT_RESET_BIT = 0;
  localparam int unsigned C1_ENABLE_BIT = 1;
  localparam int unsigned EV_TAMPER_IN_BIT = 16;
  localparam int unsigned EV_OVERFLOW_OUT_BIT = 15;
  localparam int unsigned EV_TAMPER_OUT_BIT = 14;

  // Writable bits and reset values
  localparam logic [15:0] CONTROL_TWO_MASK = 16'h77F3;
  localparam logic [31:0] EVENT_CONTROL_MASK = 32'h0001CFFF;
  localparam logic [15:0] IRQ_MASK = 16'hCFFF;
  localparam logic [15:0] CONTROL_TWO_RESET = 16'h0000;
  localparam logic [31:0] EVENT_CONTROL_RESET = 32'h00000000;
  localparam logic [15:0] IRQ_RESET = 16'h0000;
  localparam logic DEBUG_RESET = 1'h0;

  // Cycles from a write of enable or soft reset until it takes effect
  localparam logic [1:0] SYNC_CYCLES = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic spare15;
    logic [2:0] active_layer_divider;
    logic spare11;
    logic [2:0] debounce_divider;
    logic timestamp_dma_request_on;
    logic active_layer_output_on;
    logic debouncer_async_select;
    logic debouncer_majority_select;
    logic [1:0] spare3;
    logic upper_spare_regs_select;
    logic lower_spare_regs_select;
  } rce_ctrl2_t;

  // Shared layout of flags, interrupt enables and event outputs
  typedef struct packed {
    logic overflow_source;
    logic tamper;
    logic [1:0] spare;
    logic [3:0] match_source;
    logic [7:0] interval_source;
  } rce_irq_t;

endpackage : rce_pkg

// ==== verification/rce_evt_far.sv ====
module rce_evt_far
  import rce_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire rce_irq_t shot_i,
  input wire logic cap_i,
  input wire logic [15:0] count_set_i,
  input wire logic [4:0] pin_set_i,
  output logic overflow_o,
  output logic [3:0] match_o,
  output logic [7:0] interval_o,
  output logic tamper_detect_o,
  output logic capture_o,
  output logic [15:0] count_o,
  output logic [4:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins are asynchronous levels
  assign pin_o = pin_set_i;

  // Source pulses last one cycle, one clock after each request
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      overflow_o <= 1'b0;
      match_o <= 4'h0;
      interval_o <= 8'h00;
      tamper_detect_o <= 1'b0;
      capture_o <= 1'b0;
      count_o <= 16'h0000;
    end
    else
    begin
      overflow_o <= shot_i.overflow_source;
      match_o <= shot_i.match_source;
      interval_o <= shot_i.interval_source;
      tamper_detect_o <= shot_i.tamper;
      capture_o <= cap_i;
      count_o <= count_set_i;
    end
  end
endmodule : rce_evt_far

// ==== verification/tb_top.sv ====
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module tb_top
  import rce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] awaddr = 10'h000;
  logic [9:0] araddr = 10'h000;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd, gap;
  rce_irq_t shot = '0;
  rce_irq_t evt;
  logic cap = 1'b0;
  logic [15:0] cset = 16'h0000;
  logic [4:0] pset = 5'h00;
  logic ovf, det, capw, irq, dma, alc, en, dbg, prev;
  logic [3:0] mt, mon, spr;
  logic [7:0] iv;
  logic [15:0] cnt;
  logic [4:0] pin, lvl;
  logic [9:0] rst_regs [4] = '{A_CONTROL_TWO, A_EVENT_CONTROL, A_IRQ_ENABLE_SET, A_IRQ_ENABLE_CLEAR};
  int n_fail = 0;
  int n_tests = 0;
  int k, t1;

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  rce_evt_far far (.clk_i(clk_i), .rst_i(rst_i), .shot_i(shot), .cap_i(cap), .count_set_i(cset),
    .pin_set_i(pset), .overflow_o(ovf), .match_o(mt), .interval_o(iv), .tamper_detect_o(det),
    .capture_o(capw), .count_o(cnt), .pin_o(pin));

  rce_sixteen_bit_counting_mode_control dut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .count_i(cnt),
    .overflow_i(ovf), .match_i(mt), .interval_i(iv), .tamper_detect_i(det),
    .tamper_capture_evt_i(capw), .tamper_pin_i(pin), .evt_o(evt), .irq_o(irq), .dma_req_o(dma),
    .active_layer_clk_o(alc), .tamper_level_o(lvl), .match_channel_on_o(mon),
    .spare_regs_on_o(spr), .enabled_o(en), .debug_run_o(dbg));

  // Ready and valid are sampled at the falling edge, the value they hold at the next rising edge
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic ta, tw, tb, done;
    done = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(negedge clk_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bready && bvalid;
      rsp = bresp;
      @(posedge clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      done = tb;
    end
  endtask : wr

  task automatic rdt(input logic [9:0] a);
    logic ta, tr, done;
    done = 1'b0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(negedge clk_i);
      ta = arvalid && arready;
      tr = rready && rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge clk_i);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      done = tr;
    end
  endtask : rdt

  // Request sources, then stop at the falling edge where their events show
  task automatic fire(input rce_irq_t s, input logic c);
    @(posedge clk_i);
    shot <= s;
    cap <= c;
    @(posedge clk_i);
    shot <= '0;
    cap <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask : fire

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  initial
  begin
    #80000;
    n_fail++;
    $display("[ERR] watchdog expected done seen hang");
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rst_regs[i])
    begin
      rdt(rst_regs[i]);
      `CHK("reset value", 32'h00000000, rd)
    end
    rdt(10'h3FC);
    `CHK("unmapped resp", RESP_SLVERR, rsp)
    wr(10'h3FC, 32'h00000000);
    `CHK("unmapped write resp", RESP_SLVERR, rsp)
    // Protected writes while disabled
    wr(A_CONTROL_TWO, 32'h0000FFFF);
    `CHK("write resp", RESP_OKAY, rsp)
    rdt(A_CONTROL_TWO);
    `CHK("control_two", 32'h000077F3, rd)
    `CHK("match on", 4'hC, mon)
    `CHK("spare on", 4'hF, spr)
    wr(A_EVENT_CONTROL, 32'hFFFFFFFF);
    rdt(A_EVENT_CONTROL);
    `CHK("event_control", 32'h0001CFFF, rd)
    wr(A_IRQ_ENABLE_SET, 32'h00008001);
    rdt(A_IRQ_ENABLE_CLEAR);
    `CHK("enables via clear", 32'h00008001, rd)
    wr(A_IRQ_ENABLE_CLEAR, 32'h00000001);
    rdt(A_IRQ_ENABLE_SET);
    `CHK("enables via set", 32'h00008000, rd)
    wr(A_DEBUG_HALT_CONTROL, 32'h00000001);
    @(posedge clk_i);
    pset <= 5'h15;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    `CHK("debounced level", 5'h15, lvl)
    wr(A_CONTROL_ONE, 32'h00000002);
    for (k = 0; k < 20; k++)
    begin
      rdt(A_SYNC_PENDING_STATUS);
      if (rd[1:0] === 2'h0) break;
    end
    `CHK("busy cleared", 32'h00000000, rd)
    `CHK("enabled", 1'b1, en)
    wr(A_CONTROL_TWO, 32'h00000000);
    rdt(A_CONTROL_TWO);
    `CHK("protected kept", 32'h000077F3, rd)
    // Divider code 7 gives a period of 256 clocks
    gap = 32'h0;
    t1 = -1;
    prev = alc;
    for (k = 0; k < 1200 && gap == 0; k++)
    begin
      @(negedge clk_i);
      if (alc === 1'b1 && prev === 1'b0)
      begin
        if (t1 < 0) t1 = k;
        else gap = k - t1;
      end
      prev = alc;
    end
    `CHK("active clk period", 32'h00000100, gap)
    @(posedge clk_i);
    cset <= 16'hA5C3;
    fire(16'hCFFF, 1'b1);
    `CHK("event pulse", 16'hCCFF, evt)
    @(negedge clk_i);
    `CHK("event ends", 16'h0000, evt)
    `CHK("dma request", 1'b1, dma)
    rdt(A_IRQ_FLAGS);
    `CHK("flags", 32'h0000CCFF, rd)
    `CHK("irq on", 1'b1, irq)
    rdt(A_TIMESTAMP);
    `CHK("timestamp", 32'h0000A5C3, rd)
    `CHK("dma cleared", 1'b0, dma)
    rdt(A_IRQ_FLAGS);
    `CHK("tamper flag cleared", 32'h00008CFF, rd)
    wr(A_IRQ_FLAGS, 32'h00008000);
    @(negedge clk_i);
    `CHK("irq off", 1'b0, irq)
    // Soft reset together with enable: reset wins
    wr(A_CONTROL_ONE, 32'h00000003);
    for (k = 0; k < 20; k++)
    begin
      rdt(A_CONTROL_ONE);
      if (rd[0] === 1'b0) break;
    end
    `CHK("control_one", 32'h00000000, rd)
    `CHK("disabled", 1'b0, en)
    foreach (rst_regs[i])
    begin
      rdt(rst_regs[i]);
      `CHK("soft reset value", 32'h00000000, rd)
    end
    rdt(A_DEBUG_HALT_CONTROL);
    `CHK("debug kept", 32'h00000001, rd)
    `CHK("debug run", 1'b1, dbg)
    // Synchronous debouncers: majority first, then three equal samples
    wr(A_CONTROL_TWO, 32'h00000010);
    for (k = 0; k < 2; k++)
    begin
      wr(A_CONTROL_ONE, 32'h00000002);
      repeat (6) @(posedge clk_i);
      pset <= k ? 5'h15 : 5'h0A;
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
      `CHK("sync debounced level", k ? 5'h15 : 5'h0A, lvl)
      wr(A_CONTROL_ONE, 32'h00000000);
      repeat (6) @(posedge clk_i);
      `CHK("disabled again", 1'b0, en)
      wr(A_CONTROL_TWO, 32'h00000000);
    end
    conclude();
  end
endmodule : tb_top
